// file: hw/node_intermix.sv
`timescale 1ns/1ns
module node_intermix
   import intermix_pkg::*;
#(
   parameter int W     = WORD_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // link to the far end
   intermix_if.node          lnk,
   // capability advertised at login
   input  wire logic         own_cap,     // own intermix capability
   // class 1 transmit source
   input  wire logic         c1_valid,    // class 1 word to send
   output logic              c1_ready,
   input  wire logic [W-1:0] c1_data,
   input  wire logic         c1_last,
   // class 2/3 transmit source
   input  wire logic         cx_valid,    // class 2/3 word to send
   output logic              cx_ready,
   input  wire logic [W-1:0] cx_data,
   input  wire logic         cx_is3,      // 1: class 3, 0: class 2
   input  wire logic         cx_last,
   // receive side, out of the buffer
   output logic              rx_valid,    // received word
   input  wire logic         rx_ready,
   output logic      [W-1:0] rx_data,
   output logic      [1:0]   rx_class,
   output logic              rx_last,
   output logic              rx_abort,
   // status
   output logic              permit,      // interleave allowed
   output logic              rx_drop,     // pulse: word discarded
   output logic              busy_seen    // pulse: busy answer
);
   // transmit arbiter states
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_C1   = 3'b010,
      TX_CX   = 3'b100
   } tx_state_type;

   // registers
   tx_state_type tx_q;               // arbiter state
   logic         permit_q;           // registered interleave permit
   logic         drop_q;             // dropping rest of frame
   logic         rx_drop_q;          // drop pulse
   logic         busy_q;             // busy pulse
   // decode and buffer wiring
   logic         c1_sel;             // class 1 owns the link
   logic         cx_sel;             // class 2/3 owns the link
   logic         cx_allow;           // class 2/3 may go now
   logic         fin_valid;          // rx fifo fill side
   logic         fin_ready;
   logic [W+4:0] fin_data;
   logic [W+4:0] fout_data;
   logic         rx_bad;             // incoming word must be dropped

   // capability out, status outputs straight from their registers
   assign lnk.node_cap = own_cap;
   assign permit       = permit_q;
   assign rx_drop      = rx_drop_q;
   assign busy_seen    = busy_q;

   // permit follows capabilities, cleared when connection ends
   // registered so a capability change never splits a transmit decision;
   // the cost is one cycle of lag at the start of a connection
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         permit_q <= 1'b0;
      end else begin
         permit_q <= lnk.conn_up && own_cap && lnk.far_cap;
      end
   end

   // class 2/3 allowed outside a connection, or inside when permitted
   // and no class 1 word waits
   assign cx_allow = (!lnk.conn_up || permit_q) && !c1_valid;

   // frame-granular arbiter; frames keep their own class tags
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_q <= TX_IDLE;
      end else begin
         case (tx_q)
            TX_IDLE: begin
               // class 1 always wins the idle slot
               if (c1_valid) begin
                  tx_q <= TX_C1;
               end else if (cx_valid && cx_allow) begin
                  tx_q <= TX_CX;
               end
            end
            TX_C1: begin
               // hold class 1 until its last word is taken
               if (c1_valid && c1_last && lnk.n2f_ready) begin
                  tx_q <= TX_IDLE;
               end
            end
            TX_CX: begin
               // a started frame ends only on its last word, no length cap
               if (cx_valid && cx_last && lnk.n2f_ready) begin
                  tx_q <= TX_IDLE;
               end
            end
            default: begin
               // unused codes fall back to idle
               tx_q <= TX_IDLE;
            end
         endcase
      end
   end

   // the link carries the word of the source that owns it
   assign c1_sel        = (tx_q == TX_C1);
   assign cx_sel        = (tx_q == TX_CX);
   assign lnk.n2f_valid = (c1_sel && c1_valid) || (cx_sel && cx_valid);
   assign lnk.n2f_data  = cx_sel ? cx_data : c1_data;
   assign lnk.n2f_last  = cx_sel ? cx_last : c1_last;
   // each frame carries its own class, nothing extra added
   assign lnk.n2f_class = c1_sel ? CLASS_1 :
                          cx_sel ? (cx_is3 ? CLASS_3 : CLASS_2) :
                          CLASS_NONE;
   // each source sees only its own ready, no shared accounting
   assign c1_ready      = c1_sel && lnk.n2f_ready;
   assign cx_ready      = cx_sel && lnk.n2f_ready;

   // class 2/3 during a connection without both capabilities is
   // discarded; the capabilities are read directly, not through the
   // registered permit, so a frame that the far end starts in the
   // first cycle of a connection is judged like every later one
   assign rx_bad = lnk.conn_up && !(own_cap && lnk.far_cap) &&
                   (lnk.f2n_class != CLASS_1);

   // drop state covers the whole frame once its first word is bad
   // a frame ends on its last word or on an abort
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         drop_q    <= 1'b0;
         rx_drop_q <= 1'b0;
      end else begin
         rx_drop_q <= 1'b0;
         if (lnk.f2n_valid && (rx_bad || drop_q)) begin
            rx_drop_q <= 1'b1;
            drop_q    <= !lnk.f2n_last && !lnk.f2n_abort;
         end
      end
   end

   // busy answers are reported as one-cycle pulses
   // the far end already makes a pulse; this only retimes it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= lnk.f_busy;
      end
   end

   // received words of any class share one buffer
   // dropped words are still accepted so the far end never stalls
   assign fin_valid     = lnk.f2n_valid && !rx_bad && !drop_q;
   // pack abort, last, class, a spare bit and the data
   assign fin_data      = {lnk.f2n_abort, lnk.f2n_last, lnk.f2n_class,
                           1'b0, lnk.f2n_data};
   assign lnk.f2n_ready = fin_ready || rx_bad || drop_q;

   // one buffer for all classes keeps the arrival order
   word_fifo #(
      .WIDTH (W+5),
      .DEPTH (DEPTH)
   ) u_rx_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (fin_valid),
      .in_ready  (fin_ready),
      .in_data   (fin_data),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (fout_data)
   );

   // unpack the stored word
   assign rx_data  = fout_data[W-1:0];
   assign rx_class = fout_data[W+2:W+1];
   assign rx_last  = fout_data[W+3];
   assign rx_abort = fout_data[W+4];
endmodule

// file: include/intermix_pkg.sv
package intermix_pkg;
   // frame classes carried on the link
   localparam logic [1:0] CLASS_1     = 2'h1;
   localparam logic [1:0] CLASS_2     = 2'h2;
   localparam logic [1:0] CLASS_3     = 2'h3;
   localparam logic [1:0] CLASS_NONE  = 2'h0;
   // word width of the link and default fifo depth
   localparam int         WORD_W      = 32;
   localparam int         FIFO_DEPTH  = 16;
   // class 2/3 frame length in words at which the far end cuts for waiting class 1; bounds its class 1 skew
   localparam int         MAX_FRAME_W = 16;
endpackage

// file: include/intermix_if.sv
`timescale 1ns/1ns
// word link between the node port and the fabric or peer port
interface intermix_if;
   import intermix_pkg::*;
   logic              n2f_valid;    // node to far end word valid
   logic              n2f_ready;    // far end accepts word
   logic [WORD_W-1:0] n2f_data;     // word
   logic [1:0]        n2f_class;    // class of the word's frame
   logic              n2f_last;     // last word of frame
   logic              f2n_valid;    // far end to node word valid
   logic              f2n_ready;    // node accepts word
   logic [WORD_W-1:0] f2n_data;     // word
   logic [1:0]        f2n_class;    // class of the word's frame
   logic              f2n_last;     // last word of frame
   logic              f2n_abort;    // frame ended by abort delimiter
   logic              f_busy;       // one-cycle busy answer to node
   logic              node_cap;     // node intermix capability
   logic              far_cap;      // far end intermix capability
   logic              conn_up;      // dedicated connection active
   modport node (output n2f_valid, n2f_data, n2f_class, n2f_last,
                 f2n_ready, node_cap,
                 input n2f_ready, f2n_valid, f2n_data, f2n_class,
                 f2n_last, f2n_abort, f_busy, far_cap, conn_up);
   modport far (input n2f_valid, n2f_data, n2f_class, n2f_last,
                f2n_ready, node_cap,
                output n2f_ready, f2n_valid, f2n_data, f2n_class,
                f2n_last, f2n_abort, f_busy, far_cap, conn_up);
endinterface

// file: hw/word_fifo.sv
`timescale 1ns/1ns
// synchronous fifo with valid/ready on both sides
module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];  // storage
   logic [AW-1:0]    wr_q;           // write pointer
   logic [AW-1:0]    rd_q;           // read pointer
   logic [AW:0]      cnt_q;          // words held
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage write, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// file: hw/far_intermix.sv
`timescale 1ns/1ns
// far end: fabric port or peer node port facing the node port
module far_intermix
   import intermix_pkg::*;
#(
   parameter int W       = WORD_W,
   parameter int MAXF    = MAX_FRAME_W
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   intermix_if.far           lnk,
   input  wire logic         fab_cap,     // far end capability
   input  wire logic         conn_req,    // hold dedicated connection
   input  wire logic         c1_valid,    // class 1 word for node
   output logic              c1_ready,
   input  wire logic [W-1:0] c1_data,
   input  wire logic         c1_last,
   input  wire logic         cx_valid,    // class 2/3 word for node
   output logic              cx_ready,
   input  wire logic [W-1:0] cx_data,
   input  wire logic         cx_is3,
   input  wire logic         cx_last,
   output logic              cx_busy,     // pulse: class 2 refused
   output logic              cx_discard,  // pulse: class 3 dropped
   output logic              up_valid,    // word from node
   output logic      [W-1:0] up_data,
   output logic      [1:0]   up_class,
   output logic              up_last
);
   typedef enum logic [2:0] {
      DN_IDLE = 3'b001,
      DN_C1   = 3'b010,
      DN_CX   = 3'b100
   } dn_state_type;

   dn_state_type dn_q;               // downstream arbiter
   logic         conn_q;             // connection up
   logic         busy_q;             // busy pulse
   logic         disc_q;             // discard pulse
   logic [7:0]   cxcnt_q;            // words of current class 2/3 frame
   logic         refuse;             // class 2/3 frame not deliverable
   logic         abort_now;          // cut class 2/3 for class 1
   logic         up_v_q;
   logic [W-1:0] up_d_q;
   logic [1:0]   up_c_q;
   logic         up_l_q;

   assign lnk.far_cap = fab_cap;
   assign lnk.conn_up = conn_q;
   assign cx_busy     = busy_q;
   assign cx_discard  = disc_q;
   assign lnk.f_busy  = busy_q;

   // connection flag
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         conn_q <= 1'b0;
      end else begin
         conn_q <= conn_req;
      end
   end

   // during a connection, no intermix on either side refuses 2/3
   assign refuse    = conn_q && !(fab_cap && lnk.node_cap);
   // class 1 waiting past the frame bound forces an abort
   assign abort_now = (dn_q == DN_CX) && c1_valid &&
                      (cxcnt_q >= 8'(MAXF - 1));

   // downstream arbiter, class 1 first
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dn_q    <= DN_IDLE;
         cxcnt_q <= '0;
      end else begin
         case (dn_q)
            DN_IDLE: begin
               cxcnt_q <= '0;
               if (c1_valid) begin
                  dn_q <= DN_C1;
               end else if (cx_valid && !refuse) begin
                  dn_q <= DN_CX;
               end
            end
            DN_C1: begin
               if (c1_valid && c1_last && lnk.f2n_ready) begin
                  dn_q <= DN_IDLE;
               end
            end
            DN_CX: begin
               if (cx_valid && lnk.f2n_ready) begin
                  cxcnt_q <= cxcnt_q + 8'h01;
                  if (cx_last || abort_now) begin
                     dn_q <= DN_IDLE;
                  end
               end
            end
            default: begin
               dn_q <= DN_IDLE;
            end
         endcase
      end
   end

   assign lnk.f2n_valid = (dn_q == DN_C1) ? c1_valid :
                          (dn_q == DN_CX) ? cx_valid : 1'b0;
   assign lnk.f2n_data  = (dn_q == DN_CX) ? cx_data : c1_data;
   assign lnk.f2n_class = (dn_q == DN_C1) ? CLASS_1 :
                          (dn_q == DN_CX) ?
                          (cx_is3 ? CLASS_3 : CLASS_2) : CLASS_NONE;
   assign lnk.f2n_last  = (dn_q == DN_CX) ? (cx_last || abort_now)
                                          : c1_last;
   assign lnk.f2n_abort = abort_now && !cx_last;
   assign c1_ready      = (dn_q == DN_C1) && lnk.f2n_ready;
   // refused class 2/3 words are consumed, refused class 2 frames answered with busy
   assign cx_ready      = ((dn_q == DN_CX) && lnk.f2n_ready) ||
                          ((dn_q == DN_IDLE) && refuse && !c1_valid);

   // busy for refused class 2 end, silent discard for class 3
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
         disc_q <= 1'b0;
      end else begin
         busy_q <= 1'b0;
         disc_q <= 1'b0;
         if (dn_q == DN_IDLE && refuse && !c1_valid && cx_valid &&
             cx_last) begin
            busy_q <= !cx_is3;
            disc_q <= cx_is3;
         end
      end
   end

   // upstream capture, always ready
   assign lnk.n2f_ready = 1'b1;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         up_v_q <= 1'b0;
         up_d_q <= '0;
         up_c_q <= CLASS_NONE;
         up_l_q <= 1'b0;
      end else begin
         up_v_q <= lnk.n2f_valid;
         up_d_q <= lnk.n2f_data;
         up_c_q <= lnk.n2f_class;
         up_l_q <= lnk.n2f_last;
      end
   end
   assign up_valid = up_v_q;
   assign up_data  = up_d_q;
   assign up_class = up_c_q;
   assign up_last  = up_l_q;
endmodule

// file: verification/intermix_props.sv
`timescale 1ns/1ns
// link checker beside the interface joining both ends
module intermix_props
   import intermix_pkg::*;
#(
   parameter int MAXF = MAX_FRAME_W
) (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        n2f_valid,
   input wire logic        n2f_ready,
   input wire logic [31:0] n2f_data,
   input wire logic [1:0]  n2f_class,
   input wire logic        n2f_last,
   input wire logic        f2n_valid,
   input wire logic        f2n_ready,
   input wire logic [31:0] f2n_data,
   input wire logic [1:0]  f2n_class,
   input wire logic        f2n_last,
   input wire logic        f2n_abort,
   input wire logic        f_busy,
   input wire logic        node_cap,
   input wire logic        far_cap,
   input wire logic        conn_up
);
   logic       caps;   // both ends able to intermix
   logic [7:0] fcnt_q; // words so far in the far frame
   assign caps = node_cap && far_cap;
   // word counter of the far to node frame
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fcnt_q <= 8'h00;
      end else if (f2n_valid && f2n_ready) begin
         fcnt_q <= f2n_last ? 8'h00 : fcnt_q + 8'h01;
      end
   end
   default clocking dclk @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_node_no_mix: assert property (
      $past(conn_up) && conn_up && !caps && n2f_valid |-> n2f_class == CLASS_1
   ) else $error("node intermixed without permission");
   chk_far_no_mix: assert property (
      $past(conn_up) && conn_up && !caps && f2n_valid |-> f2n_class == CLASS_1
   ) else $error("far end intermixed without permission");
   chk_n2f_hold: assert property (
      n2f_valid && !n2f_ready |=> n2f_valid && $stable(n2f_data)
         && $stable(n2f_class) && $stable(n2f_last)
   ) else $error("node word changed while stalled");
   chk_f2n_hold: assert property (
      f2n_valid && !f2n_ready |=> f2n_valid && $stable(f2n_data)
         && $stable(f2n_class)
   ) else $error("far word changed while stalled");
   chk_abort_form: assert property (
      f2n_valid && f2n_abort |-> f2n_last && f2n_class != CLASS_1
   ) else $error("abort on wrong word");
   chk_frame_bound: assert property (
      f2n_valid && f2n_class != CLASS_1 |-> fcnt_q < MAXF
   ) else $error("class 2/3 frame too long");
   chk_busy_cause: assert property (
      f_busy |-> $past(conn_up) && !$past(caps)
   ) else $error("busy answer without cause");
   chk_class_coded: assert property (
      n2f_valid |-> n2f_class != CLASS_NONE
   ) else $error("node word without class");
   cov_abort: cover property (f2n_valid && f2n_abort);
   cov_busy: cover property (f_busy);
   cov_mix: cover property (conn_up && caps && n2f_valid && n2f_class[1]);
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ns
// node port and far end back to back, judged at both user sides
module testbench
   import intermix_pkg::*;
();
   logic        clk, sys_rst;        // 25 MHz clock, reset
   logic        own_cap, fab_cap;    // capabilities of both ends
   logic        conn_req, rx_ready;  // connection held, node rx ready
   logic [3:0]  sv, sl, s3;          // sources: node c1/cx, far c1/cx
   logic [31:0] sd [4];              // source data
   wire  [3:0]  sr;                  // source ready
   logic        rx_valid, rx_last, rx_abort, permit, up_valid, up_last;
   logic [31:0] rx_data, up_data;    // received words
   logic [1:0]  rx_class, up_class;  // received classes
   logic        cx_busy, cx_discard; // far refusal pulses
   logic        rx_drop, busy_seen;  // node drop and busy pulses
   logic [35:0] rxq [$], upq [$];    // words out of node, far end
   int          nbusy, ndisc, nf2n;  // refusals, link transfers
   int          nseen, ndrop;        // node busy and drop pulses
   int          failures = 0;
   int          n_compared = 0;
   intermix_if lnk ();
   node_intermix i_node_intermix (
      .clk(clk), .sys_rst(sys_rst), .lnk(lnk), .own_cap(own_cap),
      .c1_valid(sv[0]), .c1_ready(sr[0]), .c1_data(sd[0]), .c1_last(sl[0]),
      .cx_valid(sv[1]), .cx_ready(sr[1]), .cx_data(sd[1]), .cx_is3(s3[1]),
      .cx_last(sl[1]), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .rx_class(rx_class), .rx_last(rx_last),
      .rx_abort(rx_abort), .permit(permit), .rx_drop(rx_drop),
      .busy_seen(busy_seen));
   far_intermix #(.MAXF(MAX_FRAME_W)) i_far_intermix (
      .clk(clk), .sys_rst(sys_rst), .lnk(lnk), .fab_cap(fab_cap),
      .conn_req(conn_req), .c1_valid(sv[2]), .c1_ready(sr[2]),
      .c1_data(sd[2]), .c1_last(sl[2]), .cx_valid(sv[3]), .cx_ready(sr[3]),
      .cx_data(sd[3]), .cx_is3(s3[3]), .cx_last(sl[3]), .cx_busy(cx_busy),
      .cx_discard(cx_discard), .up_valid(up_valid), .up_data(up_data),
      .up_class(up_class), .up_last(up_last));
   intermix_props #(.MAXF(MAX_FRAME_W)) i_intermix_props (
      .clk(clk), .sys_rst(sys_rst), .n2f_valid(lnk.n2f_valid),
      .n2f_ready(lnk.n2f_ready), .n2f_data(lnk.n2f_data),
      .n2f_class(lnk.n2f_class), .n2f_last(lnk.n2f_last),
      .f2n_valid(lnk.f2n_valid), .f2n_ready(lnk.f2n_ready),
      .f2n_data(lnk.f2n_data), .f2n_class(lnk.f2n_class),
      .f2n_last(lnk.f2n_last), .f2n_abort(lnk.f2n_abort),
      .f_busy(lnk.f_busy), .node_cap(lnk.node_cap),
      .far_cap(lnk.far_cap), .conn_up(lnk.conn_up));
   // collect words leaving each end and count refusals
   always @(posedge clk) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
         rxq.push_back({rx_abort, rx_last, rx_class, rx_data});
      end
      if (up_valid === 1'b1) begin
         upq.push_back({1'b0, up_last, up_class, up_data});
      end
      nbusy += (cx_busy === 1'b1);
      ndisc += (cx_discard === 1'b1);
      nseen += (busy_seen === 1'b1);
      ndrop += (rx_drop === 1'b1);
      nf2n += (lnk.f2n_valid === 1'b1 && lnk.f2n_ready === 1'b1);
   end
   task automatic summarize();
      if (failures == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmp_val(input logic [35:0] g, e, input string m);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %0t %s: got %h want %h", $time, m, g, e);
      end
   endtask
   task automatic cmp_cnt(input int g, e, input string m);
      n_compared++;
      if (g != e) begin
         failures++;
         $display("[FAIL] %0t %s: got %0d want %0d", $time, m, g, e);
      end
   endtask
   // one frame from a source; node when far is 0
   task automatic send(input bit far, input logic [1:0] c, input int n,
                       input logic [31:0] b);
      int k;
      int t;
      int s;
      s = (far ? 2 : 0) + (c == CLASS_1 ? 0 : 1);
      for (k = 0; k < n; k++) begin
         sv[s] = 1'b1;
         sd[s] = b + k;
         sl[s] = (k == n - 1);
         s3[s] = (c == CLASS_3);
         t = 0;
         do begin
            @(negedge clk);
            t++;
         end while (sr[s] !== 1'b1 && t < 400);
         if (t >= 400) begin
            failures++;
            $display("[FAIL] %0t source stalled", $time);
            summarize();
         end
         @(posedge clk);
         #1;
      end
      sv[s] = 1'b0;
      // one idle edge so a following frame never re-raises valid at once
      @(posedge clk);
      #1;
   endtask
   // pops one frame from a word queue and compares each word
   task automatic take(ref logic [35:0] q[$], input logic [1:0] c,
                       input int n, input logic [31:0] b);
      int k;
      cmp_cnt(q.size() >= n, 1, "frame length");
      for (k = 0; k < n && q.size() > 0; k++) begin
         cmp_val(q.pop_front(), {1'b0, k == n - 1, c, b + k}, "word");
      end
   endtask
   // drops the connection, sets capabilities, raises it again
   task automatic connect(input logic oc, fc);
      conn_req = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      {own_cap, fab_cap, conn_req} = {oc, fc, 1'b1};
      repeat (3) @(posedge clk);
      #1;
      {nbusy, ndisc, nseen, ndrop} = 0;
   endtask
   task automatic t_basic();
      send(1, CLASS_1, 3, 32'h10);
      send(0, CLASS_3, 2, 32'h20);
      repeat (4) @(posedge clk);
      #1;
      cmp_val(permit, 1'b0, "permit idle");
      take(rxq, CLASS_1, 3, 32'h10);
      take(upq, CLASS_3, 2, 32'h20);
   endtask
   task automatic t_fifo();
      rx_ready = 1'b0;
      nf2n = 0;
      fork
         send(1, CLASS_1, 20, 32'h100);
         begin
            repeat (40) @(posedge clk);
            #1;
            cmp_cnt(nf2n, FIFO_DEPTH, "fifo fill");
            rx_ready = 1'b1;
         end
      join
      repeat (24) @(posedge clk);
      #1;
      take(rxq, CLASS_1, 20, 32'h100);
   endtask
   task automatic t_mix();
      connect(1'b1, 1'b1);
      cmp_val(permit, 1'b1, "permit up");
      send(0, CLASS_2, 2, 32'h200);
      send(1, CLASS_3, 2, 32'h300);
      fork
         send(0, CLASS_2, 2, 32'h400);
         send(0, CLASS_1, 2, 32'h500);
      join
      repeat (4) @(posedge clk);
      #1;
      take(upq, CLASS_2, 2, 32'h200);
      take(rxq, CLASS_3, 2, 32'h300);
      take(upq, CLASS_1, 2, 32'h500);
      take(upq, CLASS_2, 2, 32'h400);
      cmp_cnt(nbusy + ndisc, 0, "no refusal");
      cmp_cnt(ndrop, 0, "no drop at node");
   endtask
   task automatic t_refuse();
      int i;
      for (i = 0; i < 2; i++) begin
         connect(i == 1, i == 0);
         cmp_val(permit, 1'b0, "permit refused");
         send(1, CLASS_2, 1, 32'h600);
         send(1, CLASS_3, 1, 32'h700);
         send(1, CLASS_1, 1, 32'h800);
         send(0, CLASS_1, 1, 32'h900);
         sv[1] = 1'b1;
         repeat (10) begin
            @(negedge clk);
            cmp_val(sr[1], 1'b0, "node mix held");
         end
         @(posedge clk);
         #1;
         sv[1] = 1'b0;
         repeat (4) @(posedge clk);
         #1;
         cmp_cnt(nbusy, 1, "busy count");
         cmp_cnt(nseen, 1, "busy seen at node");
         cmp_cnt(ndisc, 1, "discard count");
         take(rxq, CLASS_1, 1, 32'h800);
         take(upq, CLASS_1, 1, 32'h900);
      end
   endtask
   task automatic t_abort();
      int ab;
      connect(1'b1, 1'b1);
      fork
         send(1, CLASS_2, 24, 32'hA00);
         begin
            repeat (4) @(posedge clk);
            #1;
            send(1, CLASS_1, 2, 32'hB00);
         end
      join
      repeat (6) @(posedge clk);
      #1;
      ab = -1;
      foreach (rxq[j]) if (ab < 0 && rxq[j][35] === 1'b1) ab = j;
      cmp_cnt(ab, MAX_FRAME_W - 1, "abort word");
      cmp_val(rxq[ab + 1], {2'h0, CLASS_1, 32'hB00}, "c1 after abort");
      rxq.delete();
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // reset, then every scenario in turn
   initial begin
      sys_rst = 1'b1;
      {own_cap, fab_cap, conn_req, rx_ready} = 4'hD;
      {sv, sl, s3} = 12'h000;
      sd = '{default: '0};
      repeat (6) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      t_basic();
      t_fifo();
      t_mix();
      t_refuse();
      t_abort();
      summarize();
   end
endmodule
